//--- i2cbh_params.svh
// Purpose: shared constants of the bridge host port
// Assumes: included by bare name, once per compilation unit
// Notes: pointer codes and upper address bits are free to change
`ifndef I2CBH_PARAMS_SVH
`define I2CBH_PARAMS_SVH
// command codes
`define I2CBH_CODE_DEVICE_RESET 8'hF0
`define I2CBH_CODE_POINTER_SELECT 8'hE1
`define I2CBH_CODE_CONFIG_WRITE 8'hD2
`define I2CBH_CODE_LINE_RESET 8'hB4
`define I2CBH_CODE_SINGLE_SLOT 8'h87
`define I2CBH_CODE_LINE_BYTE_WRITE 8'hA5
`define I2CBH_CODE_LINE_BYTE_READ 8'h96
`define I2CBH_CODE_SEARCH_TRIPLET 8'h78
// register codes carried by the pointer select parameter
`define I2CBH_PTR_STATUS 8'h01
`define I2CBH_PTR_DATA 8'h02
`define I2CBH_PTR_CONFIG 8'h03
// internal read pointer selections
`define I2CBH_SEL_STATUS 2'h0
`define I2CBH_SEL_DATA 2'h1
`define I2CBH_SEL_CONFIG 2'h2
// field positions and counts
`define I2CBH_DIR_BIT 7
`define I2CBH_BYTE_BITS 4'h8
`define I2CBH_SLAVE_ADDR_HI 5'h05
// input filter window
`define I2CBH_CLK_NS 4
`define I2CBH_FILT_NS 48
`define I2CBH_FILT_LEN (`I2CBH_FILT_NS / `I2CBH_CLK_NS)
`endif

//--- i2cbh_pkg.sv
// Purpose: types of the bridge host port
// Assumes: nothing
// Notes: enums carry no explicit codes
package i2cbh_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_ack, st_wr_byte, st_wr_ack, st_rd_byte, st_rd_ack, st_ignore
  } i2cbh_state_e;
  typedef enum logic [2:0] {
    cmd_device_reset, cmd_pointer_select, cmd_config_write, cmd_line_reset,
    cmd_single_slot, cmd_line_byte_write, cmd_line_byte_read, cmd_search_triplet
  } i2cbh_cmd_e;
  typedef enum logic [1:0] {ph_code, ph_param, ph_done} i2cbh_phase_e;
endpackage : i2cbh_pkg

//--- i2cbh_sync_filter.sv
// Purpose: two-flop synchroniser plus stability filter per input bit
// Assumes: raw inputs asynchronous to clk_i
// Notes: output follows a level only after FILT_LEN stable samples
`include "i2cbh_params.svh"
module i2cbh_sync_filter #(
  parameter int W = 4,
  parameter int FILT_LEN = `I2CBH_FILT_LEN
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bits
  input wire logic [W-1:0] raw_i,
  output logic [W-1:0] clean_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] out;
    logic [W-1:0][3:0] cnt;
  } i2cbh_filt_s;

  i2cbh_filt_s q;
  i2cbh_filt_s n;

  if (FILT_LEN < 1 || FILT_LEN > 15) begin : g_bad_len
    $error("filter length must be 1 to 15");
  end

  // s1 is read only by s2; the counters look at s2
  always_comb begin
    n = q;
    n.s1 = raw_i;
    n.s2 = q.s1;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.out[i]) begin
        n.cnt[i] = 4'h0;
      end else if (q.cnt[i] == 4'(FILT_LEN - 1)) begin
        n.out[i] = q.s2[i];
        n.cnt[i] = 4'h0;
      end else begin
        n.cnt[i] = q.cnt[i] + 4'h1;
      end
    end
  end

  // idle bus level is high, so reset to ones to avoid a false edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{s1: '1, s2: '1, out: '1, cnt: '0};
    end else begin
      q <= n;
    end
  end

  assign clean_o = q.out;
endmodule : i2cbh_sync_filter

//--- i2cbh_cmd_decode.sv
// Purpose: command and parameter acceptance, triplet write choice
// Assumes: byte_i is the byte just shifted in
// Notes: purely combinational
`include "i2cbh_params.svh"
module i2cbh_cmd_decode (
  // byte context
  input wire i2cbh_pkg::i2cbh_phase_e phase_i,
  input wire logic [7:0] code_i,
  input wire logic [7:0] byte_i,
  input wire logic busy_i,
  // triplet slots, first slot in bit 1
  input wire logic [1:0] trip_rd_i,
  input wire logic trip_dir_i,
  // decisions
  output logic ack_o,
  output logic need_param_o,
  output i2cbh_pkg::i2cbh_cmd_e kind_o,
  output logic trip_wr_o
);
  logic [7:0] sel;
  logic known;
  logic ptr_ok;

  always_comb begin
    sel = (phase_i == i2cbh_pkg::ph_code) ? byte_i : code_i;
    known = 1'b1;
    kind_o = i2cbh_pkg::cmd_device_reset;
    unique case (sel)
      `I2CBH_CODE_DEVICE_RESET: kind_o = i2cbh_pkg::cmd_device_reset;
      `I2CBH_CODE_POINTER_SELECT: kind_o = i2cbh_pkg::cmd_pointer_select;
      `I2CBH_CODE_CONFIG_WRITE: kind_o = i2cbh_pkg::cmd_config_write;
      `I2CBH_CODE_LINE_RESET: kind_o = i2cbh_pkg::cmd_line_reset;
      `I2CBH_CODE_SINGLE_SLOT: kind_o = i2cbh_pkg::cmd_single_slot;
      `I2CBH_CODE_LINE_BYTE_WRITE: kind_o = i2cbh_pkg::cmd_line_byte_write;
      `I2CBH_CODE_LINE_BYTE_READ: kind_o = i2cbh_pkg::cmd_line_byte_read;
      `I2CBH_CODE_SEARCH_TRIPLET: kind_o = i2cbh_pkg::cmd_search_triplet;
      default: known = 1'b0;
    endcase
    need_param_o = kind_o inside {i2cbh_pkg::cmd_pointer_select, i2cbh_pkg::cmd_config_write,
                                  i2cbh_pkg::cmd_single_slot, i2cbh_pkg::cmd_line_byte_write,
                                  i2cbh_pkg::cmd_search_triplet};
    ptr_ok = byte_i inside {`I2CBH_PTR_STATUS, `I2CBH_PTR_DATA, `I2CBH_PTR_CONFIG};
    unique case (phase_i)
      // pointer select and device reset are served while the line is busy
      i2cbh_pkg::ph_code: ack_o = known && (!busy_i || kind_o inside
                                  {i2cbh_pkg::cmd_device_reset, i2cbh_pkg::cmd_pointer_select});
      i2cbh_pkg::ph_param: ack_o = (kind_o != i2cbh_pkg::cmd_pointer_select) || ptr_ok;
      default: ack_o = 1'b0;
    endcase
    unique case (trip_rd_i)
      2'b00: trip_wr_o = trip_dir_i;
      2'b01: trip_wr_o = 1'b0;
      2'b10: trip_wr_o = 1'b1;
      2'b11: trip_wr_o = 1'b1;
    endcase
  end
endmodule : i2cbh_cmd_decode

//--- i2cbh_host_port.sv
// Purpose: serial slave host port of the line bridge
// Assumes: external master drives the clock; line engine on clk_i
// Notes: clock pin is input only; data pin is open drain
// Functional notes
// - only bit 7 of the triplet parameter is the chosen path
// - both triplet read slots zero: write slot equals the path value
// - bytes travel most significant bit first, each followed by an acknowledge slot
// - two strap pins set the two lowest slave address bits
// - last address bit: zero write access, one read access
// - data falling while clock high is a start; address reception begins
// - data rising while clock high is a stop; the transfer ends
// - a repeated start begins a new transfer at once
// - data changes only with clock low; sampled at clock rise
// - transmitted bits change after the falling clock edge
// - acknowledge holds data low through the acknowledge clock high phase
// - master not acknowledging a read byte makes the device release data
// - first written byte is a command, maybe followed by one parameter
// - only valid codes and expected valid parameters are acknowledged
// - reads return the pointed register, repeated for each byte
// - codes: device reset, pointer select, configuration write
// - codes: line reset, single slot, byte write start line activity
// - codes: byte read, search triplet start line activity
// - line commands during line activity are refused unacknowledged
// - clock is never driven, so no clock stretching
`include "i2cbh_params.svh"
module i2cbh_host_port #(
  parameter logic [4:0] SLAVE_ADDR_HI = `I2CBH_SLAVE_ADDR_HI,
  parameter int FILT_LEN = `I2CBH_FILT_LEN
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // address straps
  input wire logic addr_strap_pin_low_i,
  input wire logic addr_strap_pin_high_i,
  // line engine status and readable registers
  input wire logic line_busy_flag_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] read_data_i,
  input wire logic [7:0] config_i,
  input wire logic [1:0] trip_rd_i,
  // command to line engine
  output logic cmd_valid_o,
  output i2cbh_pkg::i2cbh_cmd_e cmd_o,
  output logic [7:0] cmd_param_o,
  output logic triplet_dir_o,
  output logic trip_wr_o,
  output logic [1:0] rd_ptr_o
);
  typedef struct packed {
    i2cbh_pkg::i2cbh_state_e state;
    i2cbh_pkg::i2cbh_phase_e phase;
    logic scl_d;
    logic sda_d;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic rw;
    logic drive;
    logic mack;
    logic [7:0] code;
    logic cmd_valid;
    i2cbh_pkg::i2cbh_cmd_e cmd;
    logic [7:0] param;
    logic tdir;
    logic [1:0] ptr;
    logic trip_wr;
  } i2cbh_port_s;

  i2cbh_port_s q;
  i2cbh_port_s n;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [3:0] clean;
  logic scl;
  logic sda;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic edge_ev;
  logic byte_end;
  logic [6:0] my_addr;
  logic [7:0] rd_mux;
  logic dec_ack;
  logic dec_need;
  i2cbh_pkg::i2cbh_cmd_e dec_kind;
  logic dec_trip;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  i2cbh_sync_filter #(
    .W(4),
    .FILT_LEN(FILT_LEN)
  ) u_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .raw_i({addr_strap_pin_high_i, addr_strap_pin_low_i, sda_i, scl_i}),
    .clean_o(clean)
  );

  assign scl = clean[0];
  assign sda = clean[1];
  assign my_addr = {SLAVE_ADDR_HI, clean[3], clean[2]};

  // edges judged on filtered levels only
  assign start = scl && q.scl_d && q.sda_d && !sda;
  assign stop = scl && q.scl_d && !q.sda_d && sda;
  assign rise = scl && !q.scl_d;
  assign fall = !scl && q.scl_d;
  assign edge_ev = fall || start || stop;
  assign byte_end = fall && (q.bitcnt == `I2CBH_BYTE_BITS);

  always_comb begin
    unique case (q.ptr)
      `I2CBH_SEL_STATUS: rd_mux = status_i;
      `I2CBH_SEL_DATA: rd_mux = read_data_i;
      `I2CBH_SEL_CONFIG: rd_mux = config_i;
      default: rd_mux = status_i;
    endcase
  end

  i2cbh_cmd_decode u_decode (
    .phase_i(q.phase),
    .code_i(q.code),
    .byte_i(q.sh),
    .busy_i(line_busy_flag_i),
    .trip_rd_i(trip_rd_i),
    .trip_dir_i(q.tdir),
    .ack_o(dec_ack),
    .need_param_o(dec_need),
    .kind_o(dec_kind),
    .trip_wr_o(dec_trip)
  );

  always_comb begin
    n = q;
    n.scl_d = scl;
    n.sda_d = sda;
    n.cmd_valid = 1'b0;
    n.trip_wr = dec_trip;
    if (start) begin
      // also a repeated start from any state
      n.state = i2cbh_pkg::st_addr;
      n.bitcnt = 4'h0;
      n.drive = 1'b0;
    end else if (stop) begin
      n.state = i2cbh_pkg::st_idle;
      n.drive = 1'b0;
    end else begin
      unique case (q.state)
        i2cbh_pkg::st_idle, i2cbh_pkg::st_ignore: begin
        end
        i2cbh_pkg::st_addr: begin
          if (rise) begin
            n.sh = {q.sh[6:0], sda};
            n.bitcnt = q.bitcnt + 4'h1;
          end
          if (byte_end) begin
            if (q.sh[7:1] == my_addr) begin
              n.drive = 1'b1;
              n.rw = q.sh[0];
              n.state = i2cbh_pkg::st_addr_ack;
            end else begin
              n.state = i2cbh_pkg::st_ignore;
            end
          end
        end
        i2cbh_pkg::st_addr_ack: begin
          if (fall) begin
            n.bitcnt = 4'h0;
            if (q.rw) begin
              n.sh = rd_mux;
              n.drive = !rd_mux[7];
              n.state = i2cbh_pkg::st_rd_byte;
            end else begin
              n.drive = 1'b0;
              n.phase = i2cbh_pkg::ph_code;
              n.state = i2cbh_pkg::st_wr_byte;
            end
          end
        end
        i2cbh_pkg::st_wr_byte: begin
          if (rise) begin
            n.sh = {q.sh[6:0], sda};
            n.bitcnt = q.bitcnt + 4'h1;
          end
          if (byte_end) begin
            n.drive = dec_ack;
            n.state = i2cbh_pkg::st_wr_ack;
            n.phase = i2cbh_pkg::ph_done;
            if (dec_ack && q.phase == i2cbh_pkg::ph_code) begin
              n.code = q.sh;
              if (dec_need) begin
                n.phase = i2cbh_pkg::ph_param;
              end else begin
                n.cmd_valid = 1'b1;
                n.cmd = dec_kind;
              end
            end
            if (dec_ack && q.phase == i2cbh_pkg::ph_param) begin
              n.cmd_valid = 1'b1;
              n.cmd = dec_kind;
              n.param = q.sh;
              if (dec_kind == i2cbh_pkg::cmd_search_triplet) begin
                n.tdir = q.sh[`I2CBH_DIR_BIT];
              end
            end
            // read pointer follows the accepted command
            if (dec_ack && !(q.phase == i2cbh_pkg::ph_code && dec_need)) begin
              unique case (dec_kind)
                i2cbh_pkg::cmd_pointer_select: begin
                  unique case (q.sh)
                    `I2CBH_PTR_DATA: n.ptr = `I2CBH_SEL_DATA;
                    `I2CBH_PTR_CONFIG: n.ptr = `I2CBH_SEL_CONFIG;
                    default: n.ptr = `I2CBH_SEL_STATUS;
                  endcase
                end
                i2cbh_pkg::cmd_config_write: n.ptr = `I2CBH_SEL_CONFIG;
                default: n.ptr = `I2CBH_SEL_STATUS;
              endcase
            end
          end
        end
        i2cbh_pkg::st_wr_ack: begin
          if (fall) begin
            n.drive = 1'b0;
            n.bitcnt = 4'h0;
            // surplus bytes get no acknowledge and move the port to the ignore state
            n.state = q.drive ? i2cbh_pkg::st_wr_byte : i2cbh_pkg::st_ignore;
          end
        end
        i2cbh_pkg::st_rd_byte: begin
          if (rise) begin
            n.bitcnt = q.bitcnt + 4'h1;
          end
          if (byte_end) begin
            n.drive = 1'b0;
            n.state = i2cbh_pkg::st_rd_ack;
          end else if (fall) begin
            n.sh = {q.sh[6:0], 1'b0};
            n.drive = !q.sh[6];
          end
        end
        i2cbh_pkg::st_rd_ack: begin
          if (rise) begin
            n.mack = !sda;
          end
          if (fall) begin
            n.bitcnt = 4'h0;
            if (q.mack) begin
              n.sh = rd_mux;
              n.drive = !rd_mux[7];
              n.state = i2cbh_pkg::st_rd_byte;
            end else begin
              n.drive = 1'b0;
              n.state = i2cbh_pkg::st_ignore;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // edge history starts at the idle-high bus level, no false edge
      q <= '0;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // clock pin has no driver here at all
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !q.drive;
  assign cmd_valid_o = q.cmd_valid;
  assign cmd_o = q.cmd;
  assign cmd_param_o = q.param;
  assign triplet_dir_o = q.tdir;
  assign trip_wr_o = q.trip_wr;
  assign rd_ptr_o = q.ptr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_start_addr: assert property (start |=> q.state == i2cbh_pkg::st_addr && !q.drive)
    else $error("start did not begin address reception");
  chk_stop_idle: assert property (stop && !start |=> q.state == i2cbh_pkg::st_idle && !q.drive)
    else $error("stop did not end the transfer");
  chk_addr_miss: assert property (q.state == i2cbh_pkg::st_addr && byte_end && !start && !stop
      && q.sh[7:1] != my_addr |=> q.state == i2cbh_pkg::st_ignore && !q.drive)
    else $error("foreign address was acknowledged");
  chk_dir_write: assert property (q.state == i2cbh_pkg::st_addr_ack && fall && !start && !stop
      |=> q.state == ($past(q.rw) ? i2cbh_pkg::st_rd_byte : i2cbh_pkg::st_wr_byte))
    else $error("direction bit not honoured");
  chk_msb_first: assert property (q.state == i2cbh_pkg::st_addr_ack && q.rw && fall && !stop
      && !start |=> q.drive == !$past(rd_mux[7]) && q.sh == $past(rd_mux))
    else $error("first read bit is not the register msb");
  chk_rise_sample: assert property (q.state == i2cbh_pkg::st_wr_byte && rise && !start && !stop
      |=> q.sh[0] == $past(sda))
    else $error("data not sampled at clock rise");
  chk_drive_edge: assert property ($changed(q.drive) |-> $past(edge_ev))
    else $error("data drive changed without a falling clock edge");
  chk_surplus_nack: assert property (q.state == i2cbh_pkg::st_wr_byte && byte_end && !start
      && !stop && q.phase == i2cbh_pkg::ph_done |=> !q.drive && !q.cmd_valid)
    else $error("surplus byte acknowledged");
  chk_busy_refuse: assert property (q.state == i2cbh_pkg::st_wr_byte && byte_end && !start
      && !stop && q.phase == i2cbh_pkg::ph_code && line_busy_flag_i && q.sh inside
      {`I2CBH_CODE_LINE_RESET, `I2CBH_CODE_LINE_BYTE_READ} |=> !q.drive && !q.cmd_valid)
    else $error("line command accepted while busy");
  chk_master_nack: assert property (q.state == i2cbh_pkg::st_rd_ack && fall && !q.mack
      && !start && !stop |=> !q.drive && q.state == i2cbh_pkg::st_ignore)
    else $error("data not released after master refusal");
  chk_triplet_dir: assert property (q.cmd_valid && q.cmd == i2cbh_pkg::cmd_search_triplet
      |-> q.tdir == q.param[7])
    else $error("triplet path not taken from bit 7");
  chk_triplet_write: assert property (trip_rd_i == 2'b00 |=> q.trip_wr == $past(q.tdir))
    else $error("triplet write slot does not follow path value");

  cov_cmd_taken: cover property (q.cmd_valid && q.cmd == i2cbh_pkg::cmd_search_triplet);
  cov_read_repeat: cover property (q.state == i2cbh_pkg::st_rd_ack && fall && q.mack);
  cov_rep_start: cover property (start && q.state == i2cbh_pkg::st_wr_byte);
  cov_busy_nack: cover property (q.state == i2cbh_pkg::st_wr_ack && !q.drive && line_busy_flag_i);
endmodule : i2cbh_host_port

//--- i2cbh_master_model.sv
// Purpose: behavioural serial bus master that drives the host port
// Assumes: moves only on the falling edge of clk_i; data line has a pull-up
// Notes: clock high phase of H cycles and low phase of 2H, well above the port's filter latency
module i2cbh_master_model #(
  parameter int H = 16
) (
  // clock
  input wire logic clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wt;
    repeat (H) @(negedge clk_i);
  endtask : wt

  // data set in the low phase, sampled late in the high phase
  task automatic pulse(input logic b, output logic s);
    wt();
    sda_low_o = ~b;
    wt();
    scl_o = 1'b1;
    wt();
    s = sda_i;
    scl_o = 1'b0;
  endtask : pulse

  // works from idle and as a repeated start
  task automatic start;
    // data never moves in the same step as the clock fall
    wt();
    sda_low_o = 1'b0;
    wt();
    scl_o = 1'b1;
    wt();
    sda_low_o = 1'b1;
    wt();
    scl_o = 1'b0;
  endtask : start

  task automatic stop;
    wt();
    sda_low_o = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    sda_low_o = 1'b0;
    wt();
  endtask : stop

  // d all ones when reading; mack low acknowledges a read byte
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], s);
      q[i] = s;
    end
    pulse(mack, a);
  endtask : xfer
endmodule : i2cbh_master_model

//--- i2cbh_host_port_tb.sv
// Purpose: self-checking bench of the bridge host port
// Assumes: short filter for speed; line engine side driven by the bench
// Notes: bus level is the wired-and of master and port with a pull-up
`include "i2cbh_params.svh"
`define TB_CHECK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module i2cbh_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] strap = 2'h0;
  logic busy = 1'b0;
  logic [7:0] status = 8'h3C;
  logic [7:0] rdata = 8'hC6;
  logic [7:0] cfg = 8'h5A;
  logic [1:0] trip_rd = 2'h0;
  wire logic scl;
  wire logic m_low;
  logic sda_o_w;
  logic sda_oe_n;
  wire logic sda;
  logic cmd_valid;
  i2cbh_pkg::i2cbh_cmd_e cmd;
  i2cbh_pkg::i2cbh_cmd_e last_cmd;
  logic [7:0] cmd_param;
  logic tdir;
  logic twr;
  logic [1:0] rd_ptr;
  logic [7:0] q;
  logic a;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cmd = 0;
  int k;
  logic [7:0] codes[8] = '{`I2CBH_CODE_DEVICE_RESET, `I2CBH_CODE_POINTER_SELECT,
    `I2CBH_CODE_CONFIG_WRITE, `I2CBH_CODE_LINE_RESET, `I2CBH_CODE_SINGLE_SLOT,
    `I2CBH_CODE_LINE_BYTE_WRITE, `I2CBH_CODE_LINE_BYTE_READ, `I2CBH_CODE_SEARCH_TRIPLET};
  logic hp[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [7:0] prm[8] = '{8'h00, `I2CBH_PTR_CONFIG, 8'h11, 8'h00, 8'h80, 8'h33, 8'h00, 8'h80};

  assign sda = ~m_low & (sda_oe_n | sda_o_w);

  always #2 clk = ~clk;

  i2cbh_host_port #(.FILT_LEN(2)) dut (
    .clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o_w),
    .sda_oe_n_o(sda_oe_n), .addr_strap_pin_low_i(strap[0]),
    .addr_strap_pin_high_i(strap[1]), .line_busy_flag_i(busy), .status_i(status),
    .read_data_i(rdata), .config_i(cfg), .trip_rd_i(trip_rd), .cmd_valid_o(cmd_valid),
    .cmd_o(cmd), .cmd_param_o(cmd_param), .triplet_dir_o(tdir), .trip_wr_o(twr),
    .rd_ptr_o(rd_ptr)
  );

  i2cbh_master_model #(.H(16)) m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  // commands are single-cycle pulses, so count them as they pass
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd;
    end
  end

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // nak high: the port must leave the acknowledge slot high
  task automatic send(input logic [7:0] d, input logic nak);
    m.xfer(d, 1'b1, q, a);
    `TB_CHECK("ack", nak, a)
  endtask : send

  task automatic cmd_txn(input logic [7:0] c, input logic p, input logic [7:0] pv,
                         input logic cnak, input logic pnak);
    m.start();
    send({`I2CBH_SLAVE_ADDR_HI, strap, 1'b0}, 1'b0);
    send(c, cnak);
    if (p && !cnak) send(pv, pnak);
    if (!cnak && !pnak) send(8'h00, 1'b1);
    m.stop();
    repeat (8) @(negedge clk);
  endtask : cmd_txn

  task automatic rd_txn(input logic [7:0] e, input int n);
    m.start();
    send({`I2CBH_SLAVE_ADDR_HI, strap, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i == n - 1, q, a);
      `TB_CHECK("read", e, q)
    end
    repeat (8) @(negedge clk);
    `TB_CHECK("release", 1'b1, sda_oe_n)
    m.stop();
    repeat (8) @(negedge clk);
  endtask : rd_txn

  task automatic trip_chk(input logic dir);
    `TB_CHECK("dir", dir, tdir)
    for (int j = 0; j < 4; j++) begin
      trip_rd = j[1:0];
      repeat (3) @(negedge clk);
      `TB_CHECK("trip", (j == 0) ? dir : j[1], twr)
    end
  endtask : trip_chk

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (30) @(negedge clk);
    `TB_CHECK("idle oe", 1'b1, sda_oe_n)
    `TB_CHECK("reset ptr", `I2CBH_SEL_STATUS, rd_ptr)
    `TB_CHECK("drive value", 1'b0, sda_o_w)
    rd_txn(status, 2);
    m.start();
    send({`I2CBH_SLAVE_ADDR_HI, 2'h3, 1'b0}, 1'b1);
    m.stop();
    for (int i = 0; i < 8; i++) begin
      strap = i[1:0];
      repeat (20) @(negedge clk);
      k = n_cmd;
      cmd_txn(codes[i], hp[i], prm[i], 1'b0, 1'b0);
      `TB_CHECK("count", k + 1, n_cmd)
      `TB_CHECK("cmd", i2cbh_pkg::i2cbh_cmd_e'(i[2:0]), last_cmd)
      if (hp[i]) begin
        `TB_CHECK("param", prm[i], cmd_param)
      end
    end
    trip_chk(1'b1);
    cmd_txn(`I2CBH_CODE_SEARCH_TRIPLET, 1'b1, 8'h7F, 1'b0, 1'b0);
    trip_chk(1'b0);
    // busy line engine: line commands refused, pointer still accepted
    busy = 1'b1;
    k = n_cmd;
    cmd_txn(`I2CBH_CODE_LINE_RESET, 1'b0, 8'h00, 1'b1, 1'b1);
    cmd_txn(`I2CBH_CODE_CONFIG_WRITE, 1'b1, 8'h11, 1'b1, 1'b1);
    `TB_CHECK("refused count", k, n_cmd)
    cmd_txn(`I2CBH_CODE_POINTER_SELECT, 1'b1, `I2CBH_PTR_DATA, 1'b0, 1'b0);
    `TB_CHECK("ptr", `I2CBH_SEL_DATA, rd_ptr)
    busy = 1'b0;
    rd_txn(rdata, 3);
    cmd_txn(`I2CBH_CODE_POINTER_SELECT, 1'b1, 8'h07, 1'b0, 1'b1);
    `TB_CHECK("ptr", `I2CBH_SEL_DATA, rd_ptr)
    // polling: bit 0 of the bench status stands for the busy flag
    status = 8'h3D;
    busy = 1'b1;
    cmd_txn(`I2CBH_CODE_POINTER_SELECT, 1'b1, `I2CBH_PTR_STATUS, 1'b0, 1'b0);
    `TB_CHECK("ptr", `I2CBH_SEL_STATUS, rd_ptr)
    q = 8'hFF;
    k = 0;
    while (q[0] !== 1'b0 && k < 6) begin
      if (k == 2) begin
        status = 8'h3C;
        busy = 1'b0;
      end
      rd_txn(status, 1);
      k++;
    end
    `TB_CHECK("polls", 3, k)
    m.start();
    send({`I2CBH_SLAVE_ADDR_HI, strap, 1'b0}, 1'b0);
    send(`I2CBH_CODE_POINTER_SELECT, 1'b0);
    send(`I2CBH_PTR_CONFIG, 1'b0);
    rd_txn(cfg, 2);
    wrap_up();
  end
endmodule : i2cbh_host_port_tb
